/* common/rsg_pkg.sv */
package rsg_pkg;
  // ----------------------------------------
  // image layout
  // ----------------------------------------
  localparam logic [14:0] IMG_CODE_LAST = 15'h3FFF;
  localparam logic [14:0] IMG_KEY_BASE  = 15'h4000;
  localparam logic [14:0] IMG_KEY_LAST  = 15'h403F;
  localparam logic [14:0] IMG_SEC       = 15'h4040;
  localparam int          SEC_FETCH_BIT = 0;
  localparam int          SEC_VFY_BIT   = 1;
  // ----------------------------------------
  // reset and unprogrammed values, hidden read value, pin capture count
  // ----------------------------------------
  localparam logic [7:0]  KEY_BLANK     = 8'hFF;
  localparam logic [1:0]  SEC_BLANK     = 2'h3;
  localparam logic [7:0]  HIDDEN_BYTE   = 8'hFF;
  localparam logic [1:0]  EA_SETTLE     = 2'h2;
  // ----------------------------------------
  // register word offsets (byte address), status bits, bus codes
  // ----------------------------------------
  localparam logic [7:0]  OFS_ADDR      = 8'h00;
  localparam logic [7:0]  OFS_DATA      = 8'h04;
  localparam logic [7:0]  OFS_STAT      = 8'h08;
  localparam int          ST_FETCH_LOCK = 0;
  localparam int          ST_VFY_LOCK   = 1;
  localparam int          ST_EA_LEVEL   = 2;
  localparam int          ST_REFUSED    = 3;
  localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0]  HRESP_OKAY    = 2'h0;

  typedef struct packed {
    logic             wr_pend;
    logic [7:0]       wr_ofs;
    logic             rd_pend;
    logic [7:0]       rd_ofs;
    logic [31:0]      rdata;
    logic [14:0]      img_addr;
    logic [1:0]       sec;
    logic [63:0][7:0] key;
    logic             refused;
    logic [1:0]       ea_sync;
    logic             ea_hold;
    logic [1:0]       ea_cnt;
    logic [7:0]       fdata;
    logic             fvalid;
  } rsg_state_t;
endpackage

/* core/rsg_gate.sv */
// Contract
// - no security bit programmed: code bytes readable in verify mode
// - key programmed: verify returns encrypted code bytes only
// - encrypted byte is stored byte XNOR selected key byte
// - fetch lock: external code-table reads cannot obtain internal bytes
// - fetch lock: external access pin latched at reset, not followed
// - fetch lock: further program memory programming refused
// - both lock bits: verify mode disabled entirely
// - key store holds 64 bytes, blank value all ones
// - key sits at 4000H-403FH; key byte FFH means no encryption
// - byte 4040H: bit0 fetch lock, bit1 verify lock, 0 enables
//
// Added by the designer: register access over AHB-Lite and the register offsets.
module rsg_gate
  import rsg_pkg::*;
#(
  parameter int CODE_DEPTH = 16384
)(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic      [1:0]  hresp,
  input  wire logic        external_access_pin,
  output logic             ext_access_eff,
  input  wire logic        fetch_req,
  input  wire logic [13:0] fetch_addr,
  input  wire logic        fetch_from_ext,
  output logic      [7:0]  fetch_data,
  output logic             fetch_valid
);
  import rsg_pkg::*;

  rsg_state_t s_q;
  rsg_state_t s_d;
  logic [7:0] code_mem [CODE_DEPTH];
  logic       fetch_lock;
  logic       vfy_lock;
  logic       prog_code;
  logic       take;
  logic [7:0] vfy_byte;

  // ----------------------------------------
  // lock decode
  // ----------------------------------------
  // lock bits active low
  assign fetch_lock = !s_q.sec[SEC_FETCH_BIT];
  assign vfy_lock   = fetch_lock && !s_q.sec[SEC_VFY_BIT];

  // ----------------------------------------
  // bus answers
  // ----------------------------------------
  // one wait state on reads so a read sees a just-written address
  assign hreadyout = !s_q.rd_pend;
  assign hresp     = HRESP_OKAY;
  assign hrdata    = s_q.rdata;
  assign take      = hsel && hready && (htrans == HTRANS_NONSEQ);
  assign fetch_data  = s_q.fdata;
  assign fetch_valid = s_q.fvalid;
  assign ext_access_eff = fetch_lock ? s_q.ea_hold : s_q.ea_sync[1];

  // ----------------------------------------
  // verify read path
  // ----------------------------------------
  always_comb
  begin
    vfy_byte = HIDDEN_BYTE;
    if (!vfy_lock && (s_q.img_addr <= IMG_CODE_LAST))
    begin
      // a blank key byte leaves data as stored
      vfy_byte = ~(code_mem[s_q.img_addr[13:0]] ^ s_q.key[s_q.img_addr[5:0]]);
    end
  end

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb
  begin
    s_d        = s_q;
    s_d.fvalid = 1'b0;
    prog_code  = 1'b0;
    // address phase capture
    s_d.wr_pend = take && hwrite;
    if (take && hwrite)
    begin
      s_d.wr_ofs = haddr[7:0];
    end
    if (s_q.rd_pend)
    begin
      s_d.rd_pend = 1'b0;
      s_d.rdata   = 32'h0000_0000;
      unique case (s_q.rd_ofs)
        OFS_ADDR: s_d.rdata = {17'h0_0000, s_q.img_addr};
        OFS_DATA: s_d.rdata = {24'h00_0000, vfy_byte};
        OFS_STAT:
        begin
          s_d.rdata[ST_FETCH_LOCK] = fetch_lock;
          s_d.rdata[ST_VFY_LOCK]   = vfy_lock;
          s_d.rdata[ST_EA_LEVEL]   = ext_access_eff;
          s_d.rdata[ST_REFUSED]    = s_q.refused;
        end
        default: s_d.rdata = 32'h0000_0000;
      endcase
    end
    else if (take && !hwrite)
    begin
      s_d.rd_pend = 1'b1;
      s_d.rd_ofs  = haddr[7:0];
    end
    // data phase of a write
    if (s_q.wr_pend)
    begin
      unique case (s_q.wr_ofs)
        OFS_ADDR: s_d.img_addr = hwdata[14:0];
        OFS_DATA:
        begin
          if (s_q.img_addr == IMG_SEC)
          begin
            s_d.sec = s_q.sec & hwdata[1:0];
          end
          // code and key frozen under lock
          else if (fetch_lock)
          begin
            s_d.refused = 1'b1;
          end
          else if (s_q.img_addr <= IMG_CODE_LAST)
          begin
            prog_code = 1'b1;
          end
          else if (s_q.img_addr <= IMG_KEY_LAST)
          begin
            s_d.key[s_q.img_addr[5:0]] = hwdata[7:0];
          end
        end
        // a one in the refused bit clears the refusal flag; no refusal can fall in the same write
        OFS_STAT:
        begin
          if (hwdata[ST_REFUSED])
          begin
            s_d.refused = 1'b0;
          end
        end
        default: s_d.refused = s_q.refused;
      endcase
    end
    // pin synchroniser, then a one-shot capture after reset
    s_d.ea_sync = {s_q.ea_sync[0], external_access_pin};
    if (s_q.ea_cnt <= EA_SETTLE)
    begin
      s_d.ea_cnt = s_q.ea_cnt + 2'h1;
      // second flop holds the pin only from this edge on
      if (s_q.ea_cnt == EA_SETTLE)
      begin
        s_d.ea_hold = s_q.ea_sync[1];
      end
    end
    // code-table read port
    if (fetch_req)
    begin
      s_d.fvalid = 1'b1;
      if (fetch_lock && fetch_from_ext)
      begin
        s_d.fdata = HIDDEN_BYTE;
      end
      else
      begin
        s_d.fdata = code_mem[fetch_addr];
      end
    end
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      s_q      <= '0;
      s_q.key  <= {64{KEY_BLANK}};
      s_q.sec  <= SEC_BLANK;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // array holds no reset: a mask image survives reset
  always_ff @(posedge hclk)
  begin
    if (prog_code)
    begin
      code_mem[s_q.img_addr[13:0]] <= hwdata[7:0];
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence rd_data_s;
    s_q.rd_pend && (s_q.rd_ofs == OFS_DATA);
  endsequence

  sequence code_wr_s;
    s_q.wr_pend && (s_q.wr_ofs == OFS_DATA) && (s_q.img_addr <= IMG_KEY_LAST);
  endsequence

  verify_off_a: assert property (
    rd_data_s and (vfy_lock) |=> hrdata == 32'h0000_00FF)
    else $error("verify data visible while verify is locked");

  verify_xnor_a: assert property (
    rd_data_s and (!vfy_lock && s_q.img_addr <= IMG_CODE_LAST)
    |=> hrdata[7:0] == ~($past(code_mem[s_q.img_addr[13:0]])
                         ^ $past(s_q.key[s_q.img_addr[5:0]])))
    else $error("verify byte not stored xnor key");

  fetch_block_a: assert property (
    fetch_req && fetch_from_ext && fetch_lock
    |=> fetch_valid && fetch_data == 8'hFF)
    else $error("external table read reached internal code");

  ea_latch_a: assert property (
    fetch_lock && (s_q.ea_cnt > EA_SETTLE) ##1 fetch_lock |-> $stable(ext_access_eff))
    else $error("pin level followed under fetch lock");

  prog_refuse_a: assert property (
    code_wr_s and (fetch_lock) |=> s_q.refused && $stable(s_q.key) && !$past(prog_code))
    else $error("programming accepted under fetch lock");

  key_store_a: assert property (
    code_wr_s and (!fetch_lock && s_q.img_addr >= IMG_KEY_BASE)
    |=> s_q.key[$past(s_q.img_addr[5:0])] == $past(hwdata[7:0]))
    else $error("key byte not stored");

  sec_write_a: assert property (
    s_q.wr_pend && s_q.wr_ofs == OFS_DATA && s_q.img_addr == IMG_SEC && !hwdata[0]
    |=> fetch_lock [*3])
    else $error("fetch lock not set by image byte bit 0");

  read_wait_a: assert property (
    take && !hwrite && hreadyout |=> !hreadyout ##1 hreadyout)
    else $error("read not answered after one wait state");

  verify_raw_a: assert property (
    rd_data_s and (!vfy_lock && s_q.img_addr <= IMG_CODE_LAST
                   && s_q.key[s_q.img_addr[5:0]] == KEY_BLANK)
    |=> hrdata[7:0] == $past(code_mem[s_q.img_addr[13:0]]))
    else $error("blank key changed verify byte");

  key_hidden_a: assert property (
    rd_data_s and (s_q.img_addr > IMG_CODE_LAST)
    |=> hrdata == {24'h00_0000, HIDDEN_BYTE})
    else $error("key or security byte readable");

  fetch_open_a: assert property (
    fetch_req && !(fetch_lock && fetch_from_ext)
    |=> fetch_valid && fetch_data == $past(code_mem[fetch_addr]))
    else $error("internal table read not served");

  fetch_pulse_a: assert property (
    fetch_valid |-> $past(fetch_req))
    else $error("table read answer without request");

  code_frozen_a: assert property (
    fetch_lock |-> !prog_code)
    else $error("code byte programmed under fetch lock");

  refuse_hold_a: assert property (
    s_q.refused && !(s_q.wr_pend && s_q.wr_ofs == OFS_STAT && hwdata[ST_REFUSED])
    |=> s_q.refused)
    else $error("refusal flag lost without clear");

  lock_sticky_a: assert property (
    fetch_lock |=> fetch_lock)
    else $error("fetch lock undone while running");

  verify_sticky_a: assert property (
    vfy_lock |=> vfy_lock)
    else $error("verify lock undone while running");

  ea_capture_a: assert property (
    s_q.ea_cnt == EA_SETTLE |=> s_q.ea_hold == $past(s_q.ea_sync[1]))
    else $error("pin level not captured after reset");
endmodule

/* bench/rsg_programmer.sv */
module rsg_programmer
(
  input  wire logic        hclk,
  input  wire logic [31:0] hrdata,
  input  wire logic        hreadyout,
  output logic             hsel,
  output logic      [31:0] haddr,
  output logic      [1:0]  htrans,
  output logic             hwrite,
  output logic      [2:0]  hsize,
  output logic      [31:0] hwdata
);
  timeunit 1ns;
  timeprecision 100ps;
  import rsg_pkg::*;

  initial
  begin
    hsel = 1'b1;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
  end

  // ----------------------------------------
  // bus cycle
  // ----------------------------------------
  // no fixed latency assumed: bench watchdog ends a hang
  task automatic xfer(input logic w, input logic [31:0] a, d, output logic [31:0] r);
    haddr <= a;
    hwrite <= w;
    hsize <= 3'h2;
    htrans <= HTRANS_NONSEQ;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask

  // ----------------------------------------
  // image access
  // ----------------------------------------
  // code and key bytes
  task automatic prog(input logic [14:0] ia, input logic [7:0] b);
    logic [31:0] r;
    xfer(1'b1, {24'h0, OFS_ADDR}, {17'h0, ia}, r);
    xfer(1'b1, {24'h0, OFS_DATA}, {24'h0, b}, r);
  endtask

  task automatic vfy(input logic [14:0] ia, output logic [31:0] r);
    xfer(1'b1, {24'h0, OFS_ADDR}, {17'h0, ia}, r);
    xfer(1'b0, {24'h0, OFS_DATA}, 32'h0, r);
  endtask

  task automatic lock(input logic both);
    prog(IMG_SEC, {6'h3F, ~both, 1'b0});
  endtask
endmodule

/* bench/test_rom_security_encryption_gate.sv */
module test_rom_security_encryption_gate;
  timeunit 1ns;
  timeprecision 100ps;
  import rsg_pkg::*;

  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic [1:0]  hresp;
  logic [2:0]  hsize;
  logic        ea_pin = 1'b1;
  logic        ea_eff;
  logic        fetch_req = 1'b0;
  logic [13:0] fetch_addr = 14'h0;
  logic        fetch_ext = 1'b0;
  logic [7:0]  fetch_data;
  logic        fetch_valid;
  logic [31:0] r;
  int          n_mismatch = 0;
  int          samples_checked = 0;

  always #2 hclk = ~hclk;

  rsg_gate dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .external_access_pin(ea_pin), .ext_access_eff(ea_eff), .fetch_req(fetch_req),
    .fetch_addr(fetch_addr), .fetch_from_ext(fetch_ext), .fetch_data(fetch_data),
    .fetch_valid(fetch_valid));

  rsg_programmer prg (.hclk(hclk), .hrdata(hrdata), .hreadyout(hreadyout),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata));

  // ----------------------------------------
  // checks
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, exp);
    samples_checked++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic stat(input logic [31:0] exp);
    prg.xfer(1'b0, {24'h0, OFS_STAT}, 32'h0, r);
    chk(r, exp);
  endtask

  task automatic code(input logic [14:0] ia, input logic [7:0] exp);
    prg.vfy(ia, r);
    chk(r, {24'h0, exp});
  endtask

  // valid lands the cycle after the request edge
  task automatic fetch(input logic ext, input logic [7:0] exp);
    fetch_req <= 1'b1;
    fetch_addr <= 14'h10;
    fetch_ext <= ext;
    @(posedge hclk);
    fetch_req <= 1'b0;
    #1;
    chk({31'h0, fetch_valid}, 32'h1);
    chk({24'h0, fetch_data}, {24'h0, exp});
    @(posedge hclk);
  endtask

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial
  begin
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    stat(32'h4); // no lock
    code(IMG_KEY_BASE, 8'hFF); // key byte hidden
    prg.prog(15'h0010, 8'h5A);
    code(15'h0010, 8'h5A); // raw byte
    prg.prog(15'h4010, 8'h0F);
    code(15'h0010, 8'hAA); // xnor
    code(15'h4010, 8'hFF); // key hidden
    fetch(1'b1, 8'h5A); // open
    $display("test open done");
    prg.lock(1'b0);
    ea_pin <= 1'b0;
    repeat (4) @(posedge hclk);
    stat(32'h5); // pin held
    chk({31'h0, ea_eff}, 32'h1); // held level at pin
    prg.prog(15'h0010, 8'h00);
    prg.prog(15'h4010, 8'h00);
    stat(32'hD); // refused
    code(15'h0010, 8'hAA); // code and key unchanged
    prg.xfer(1'b1, {24'h0, OFS_STAT}, 32'h8, r);
    stat(32'h5); // cleared
    fetch(1'b1, 8'hFF); // blocked
    fetch(1'b0, 8'h5A); // internal ok
    $display("test fetch lock done");
    prg.lock(1'b1);
    stat(32'h7); // both
    code(15'h0010, 8'hFF); // hidden
    prg.xfer(1'b0, 32'h0C, 32'h0, r);
    chk(r, 32'h0);
    chk({30'h0, hresp}, 32'h0);
    $display("test verify lock done");
    hresetn <= 1'b0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    stat(32'h0); // unlocked again, pin low
    code(15'h0010, 8'h5A); // blank key again, code kept
    chk({31'h0, ea_eff}, 32'h0); // unlocked pin followed
    $display("test reset done");
    tally_and_finish();
  end

  // about 110 cycles expected; generous margin
  initial
  begin
    #20000;
    n_mismatch++;
    tally_and_finish();
  end
endmodule
